// File: design/prt_pkg.sv
// Shared constants, types and helper functions for the pattern-unlocked timekeeper
package prt_pkg;
    // Bus and key geometry
    localparam logic [63:0] KEY          = 64'h5CA3_3AC5_5CA3_3AC5;
    localparam logic [5:0]  LAST_BIT     = 6'h3F;
    localparam logic [2:0]  LAST_IN_BYTE = 3'h7;

    // Register indexes inside the 64-bit image
    localparam logic [2:0] R_HUND = 3'h0;
    localparam logic [2:0] R_SEC  = 3'h1;
    localparam logic [2:0] R_MIN  = 3'h2;
    localparam logic [2:0] R_HOUR = 3'h3;
    localparam logic [2:0] R_DAY  = 3'h4;
    localparam logic [2:0] R_DATE = 3'h5;
    localparam logic [2:0] R_MON  = 3'h6;
    localparam logic [2:0] R_YEAR = 3'h7;
    localparam int         N_REGS = 8;

    // Field positions
    localparam int HR_FMT_BIT     = 7;
    localparam int HR_PM_BIT      = 5;
    localparam int DAY_RSTIGN_BIT = 4;
    localparam int DAY_OSCOFF_BIT = 5;

    // Reset image (reg7..reg0) and writable-bit masks
    localparam logic [63:0] TM_RST    = 64'h0001_0121_0000_0000;
    localparam logic [63:0] ZERO_MASK = 64'hFF1F_3F37_BF7F_7FFF;

    // BCD limits
    localparam logic [7:0] BCD_01  = 8'h01;
    localparam logic [7:0] BCD_59  = 8'h59;
    localparam logic [7:0] BCD_99  = 8'h99;
    localparam logic [7:0] BCD_DEC = 8'h12;
    localparam logic [5:0] BCD_23  = 6'h23;
    localparam logic [4:0] BCD_11  = 5'h11;
    localparam logic [4:0] BCD_12  = 5'h12;
    localparam logic [4:0] H12_ONE = 5'h01;
    localparam logic [2:0] DOW_1   = 3'h1;
    localparam logic [2:0] DOW_7   = 3'h7;

    // Timing: hundredths tick from the 50 MHz system clock
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned TICK_PERIOD_NS = 10_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_LOCKED, ST_MATCH, ST_MISS, ST_XFER} prt_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic din;
    } prt_cyc_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] x);
        if (x[3:0] == 4'h9)
            bcd_inc = {4'(x[7:4] + 4'h1), 4'h0};
        else
            bcd_inc = 8'(x + 8'h01);
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4])
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        else
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic leap);
        unique case (m)
            8'h02:                      month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    endfunction
endpackage

// File: design/prt_tick.sv
// Hundredths-of-a-second tick divider
`timescale 1ns/1ps
module prt_tick #(
    parameter int unsigned CYCLES = prt_pkg::TICK_CYCLES
) (
    input  wire logic sys_clk, // System clock
    input  wire logic rstn,    // Synchronous reset, active low
    input  wire logic clk_en,  // Freezes state while low
    input  wire logic run,     // Oscillator running
    output logic      tick     // One pulse per hundredth
);
    localparam int unsigned W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_q;
    wire  logic   wrap;

    assign wrap = (cnt_q == W'(CYCLES - 1));

    // A stopped oscillator also restarts the divider from zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (clk_en) begin
            tick  <= run && wrap;
            cnt_q <= (!run || wrap) ? '0 : W'(cnt_q + 1'b1);
        end
    end
endmodule

// File: design/prt_cycle.sv
// Bus cycle detector: one event per select cycle with a strobe, at its trailing edge
`timescale 1ns/1ps
module prt_cycle (
    input  wire logic         sys_clk,     // System clock
    input  wire logic         rstn,        // Synchronous reset, active low
    input  wire logic         clk_en,      // Freezes state while low
    input  wire logic         select_in_n, // Device select, active low
    input  wire logic         read_n,      // Read strobe, active low
    input  wire logic         write_n,     // Write strobe, active low
    input  wire logic         data_in,     // Serial data input
    output prt_pkg::prt_cyc_t cyc          // Cycle event, one-cycle pulse
);
    logic sel_q;
    logic rd_q;
    logic wr_q;
    logic din_q;
    wire  logic ends;

    // RULE24 - trailing select edge
    // RULE10 - unselected cycles unseen
    assign ends    = clk_en && !sel_q && select_in_n;
    assign cyc.wr  = ends && !wr_q;
    assign cyc.rd  = ends && wr_q && !rd_q;
    assign cyc.din = din_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sel_q <= 1'b1;
            rd_q  <= 1'b1;
            wr_q  <= 1'b1;
            din_q <= 1'b0;
        end else if (clk_en) begin
            sel_q <= select_in_n;
            rd_q  <= read_n;
            wr_q  <= write_n;
            din_q <= data_in;
        end
    end
endmodule

// File: design/prt_rtc.sv
// Pattern-unlocked serial timekeeper placed in series with a memory select
`timescale 1ns/1ps

// How it works
// RULE1 - Before full key recognition, memory select output follows select input.
// RULE2 - A read cycle starts recognition, pointer at first key bit.
// RULE3 - Each write compares data bit with key bit; match advances pointer.
// RULE4 - A mismatch holds the pointer; later writes of that attempt ignored.
// RULE5 - A read during recognition aborts and returns pointer to start.
// RULE6 - Key is C5 3A A3 5C twice, sixty-four write cycles.
// RULE7 - Key bytes are sent least significant bit first.
// RULE8 - After unlock, 64 cycles transfer bits: writes take, reads drive.
// RULE9 - Memory select output held high during the 64 transfer cycles.
// RULE10 - Cycles without select asserted disturb neither recognition nor transfer.
// RULE11 - Eight 8-bit registers, register 0 bit 0 through register 7 bit 7.
// RULE12 - Time registers hold and report BCD values.
// RULE13 - Host writes registers only as whole bytes.
// RULE14 - Hours bit 7 high selects 12-hour mode, low 24-hour.
// RULE15 - Hours bit 5 is afternoon flag in 12h, tens bit in 24h.
// RULE16 - Day bit 4 low lets abort pin end a transfer, time untouched.
// RULE17 - Abort pin acts whatever select and strobes are doing.
// RULE18 - Day bit 5 low runs oscillator and counters; high stops them.
// RULE19 - Unused bits in registers 1 to 6 read zero, writes accepted.
// RULE20 - Counts hundredths to year, short months and leap years handled.
// RULE21 - Power fail aborts transfer, time untouched, access refused until recovery.
// RULE22 - RAM mode: select passes through, forced high on power fail.
// RULE23 - ROM mode: memory select forced low on power fail.
// RULE24 - Each access counts once at select trailing edge with a strobe.
module prt_rtc #(
    parameter int unsigned TICK_CYCLES = prt_pkg::TICK_CYCLES
) (
    input  wire logic sys_clk,             // System clock, 50 MHz
    input  wire logic rstn,                // Synchronous reset, active low
    input  wire logic clk_en,              // Freezes all state while low
    input  wire logic select_in_n,         // Device select, active low
    input  wire logic read_n,              // Read strobe, active low
    input  wire logic write_n,             // Write strobe, active low
    input  wire logic data_in,             // Serial data input
    input  wire logic abort_n,             // Abort pin, active low
    input  wire logic rom_mode,            // Memory-type select, high for ROM
    input  wire logic below_trip_level,    // Main supply under trip level
    output logic      memory_select_out_n, // Memory select, active low
    output logic      data_out,            // Serial data output
    output logic      data_out_oe          // Data output drive enable
);
    prt_pkg::prt_state_t st_q;
    prt_pkg::prt_state_t st_d;
    logic [5:0]          ptr_q;
    logic [5:0]          ptr_d;
    logic [63:0]         shad_q;
    logic [63:0]         shad_nx;
    logic                wr_any_q;
    logic [7:0]          tm_q [prt_pkg::N_REGS];
    logic [7:0]          tm_d [prt_pkg::N_REGS];
    logic [63:0]         tm_img;
    prt_pkg::prt_cyc_t   cyc;
    wire  logic          tick;
    wire  logic          osc_run;
    wire  logic          abort;
    wire  logic          key_ok;
    wire  logic          unlock;
    wire  logic          xfer_step;
    wire  logic          commit;
    wire  logic [7:0]    commit_byte;
    wire  logic [7:0]    commit_mask;

    prt_cycle u_cycle (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .clk_en      (clk_en),
        .select_in_n (select_in_n),
        .read_n      (read_n),
        .write_n     (write_n),
        .data_in     (data_in),
        .cyc         (cyc)
    );

    // RULE18 - oscillator enable bit
    assign osc_run = !tm_q[prt_pkg::R_DAY][prt_pkg::DAY_OSCOFF_BIT];

    prt_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .run     (osc_run),
        .tick    (tick)
    );

    // RULE16 - gated abort pin
    // RULE17 - independent of strobes
    // RULE21 - power fail aborts
    assign abort = (!abort_n && !tm_q[prt_pkg::R_DAY][prt_pkg::DAY_RSTIGN_BIT])
                   || below_trip_level;

    // RULE6 - key bit lookup
    // RULE7 - LSB first within byte
    assign key_ok    = (cyc.din == prt_pkg::KEY[ptr_q]);
    assign unlock    = (st_q == prt_pkg::ST_MATCH) && cyc.wr && key_ok
                       && (ptr_q == prt_pkg::LAST_BIT) && !abort;
    assign xfer_step = (st_q == prt_pkg::ST_XFER) && (cyc.rd || cyc.wr) && !abort;

    // RULE13 - whole bytes commit
    assign commit      = xfer_step && (ptr_q[2:0] == prt_pkg::LAST_IN_BYTE)
                         && (wr_any_q || cyc.wr);
    assign commit_byte = shad_nx[{ptr_q[5:3], 3'h0} +: 8];
    assign commit_mask = prt_pkg::ZERO_MASK[{ptr_q[5:3], 3'h0} +: 8];

    always_comb begin
        shad_nx = shad_q;
        if (cyc.wr)
            shad_nx[ptr_q] = cyc.din;
    end

    always_comb begin
        for (int i = 0; i < prt_pkg::N_REGS; i++)
            tm_img[i*8 +: 8] = tm_q[i];
    end

    // Recognition and transfer sequencer
    always_comb begin
        st_d  = st_q;
        ptr_d = ptr_q;
        if (abort) begin
            st_d  = prt_pkg::ST_LOCKED;
            ptr_d = '0;
        end else begin
            unique case (st_q)
                // RULE2 - read arms recognition
                prt_pkg::ST_LOCKED, prt_pkg::ST_MISS: begin
                    if (cyc.rd) begin
                        st_d  = prt_pkg::ST_MATCH;
                        ptr_d = '0;
                    end
                end
                prt_pkg::ST_MATCH: begin
                    // RULE5 - read restarts attempt
                    if (cyc.rd) begin
                        ptr_d = '0;
                    end else if (cyc.wr) begin
                        // RULE3 - compare and advance
                        // RULE4 - mismatch holds pointer
                        if (!key_ok) begin
                            st_d = prt_pkg::ST_MISS;
                        end else if (ptr_q == prt_pkg::LAST_BIT) begin
                            st_d  = prt_pkg::ST_XFER;
                            ptr_d = '0;
                        end else begin
                            ptr_d = 6'(ptr_q + 1'b1);
                        end
                    end
                end
                // RULE8 - one bit per cycle
                // RULE11 - reg 0 bit 0 upward
                prt_pkg::ST_XFER: begin
                    if (cyc.rd || cyc.wr) begin
                        ptr_d = 6'(ptr_q + 1'b1);
                        if (ptr_q == prt_pkg::LAST_BIT)
                            st_d = prt_pkg::ST_LOCKED;
                    end
                end
            endcase
        end
    end

    // RULE20 - calendar counting chain
    always_comb begin
        logic       c;
        logic [4:0] hr;
        logic       pm;
        logic [7:0] mon;
        c   = tick && osc_run;
        hr  = tm_q[prt_pkg::R_HOUR][4:0];
        pm  = tm_q[prt_pkg::R_HOUR][prt_pkg::HR_PM_BIT];
        mon = tm_q[prt_pkg::R_MON];
        for (int i = 0; i < prt_pkg::N_REGS; i++)
            tm_d[i] = tm_q[i];
        // RULE12 - BCD arithmetic
        if (c) begin
            c = (tm_q[prt_pkg::R_HUND] == prt_pkg::BCD_99);
            tm_d[prt_pkg::R_HUND] = c ? '0 : prt_pkg::bcd_inc(tm_q[prt_pkg::R_HUND]);
        end
        if (c) begin
            c = (tm_q[prt_pkg::R_SEC] == prt_pkg::BCD_59);
            tm_d[prt_pkg::R_SEC] = c ? '0 : prt_pkg::bcd_inc(tm_q[prt_pkg::R_SEC]);
        end
        if (c) begin
            c = (tm_q[prt_pkg::R_MIN] == prt_pkg::BCD_59);
            tm_d[prt_pkg::R_MIN] = c ? '0 : prt_pkg::bcd_inc(tm_q[prt_pkg::R_MIN]);
        end
        if (c) begin
            // RULE14 - format select
            // RULE15 - afternoon or tens bit
            if (tm_q[prt_pkg::R_HOUR][prt_pkg::HR_FMT_BIT]) begin
                c = (hr == prt_pkg::BCD_11) && pm;
                if (hr == prt_pkg::BCD_11)
                    pm = !pm;
                hr = (hr == prt_pkg::BCD_12) ? prt_pkg::H12_ONE
                                             : 5'(prt_pkg::bcd_inc({3'h0, hr}));
                tm_d[prt_pkg::R_HOUR] = {tm_q[prt_pkg::R_HOUR][7:6], pm, hr};
            end else begin
                c = (tm_q[prt_pkg::R_HOUR][5:0] == prt_pkg::BCD_23);
                tm_d[prt_pkg::R_HOUR] = {tm_q[prt_pkg::R_HOUR][7:6],
                    c ? 6'h00 : 6'(prt_pkg::bcd_inc({2'h0, tm_q[prt_pkg::R_HOUR][5:0]}))};
            end
        end
        if (c) begin
            tm_d[prt_pkg::R_DAY][2:0] = (tm_q[prt_pkg::R_DAY][2:0] == prt_pkg::DOW_7)
                ? prt_pkg::DOW_1 : 3'(tm_q[prt_pkg::R_DAY][2:0] + 1'b1);
            c = (tm_q[prt_pkg::R_DATE] ==
                 prt_pkg::month_len(mon, prt_pkg::is_leap(tm_q[prt_pkg::R_YEAR])));
            tm_d[prt_pkg::R_DATE] = c ? prt_pkg::BCD_01
                                      : prt_pkg::bcd_inc(tm_q[prt_pkg::R_DATE]);
        end
        if (c) begin
            c = (mon == prt_pkg::BCD_DEC);
            tm_d[prt_pkg::R_MON] = c ? prt_pkg::BCD_01 : prt_pkg::bcd_inc(mon);
        end
        if (c) begin
            tm_d[prt_pkg::R_YEAR] = (tm_q[prt_pkg::R_YEAR] == prt_pkg::BCD_99)
                ? '0 : prt_pkg::bcd_inc(tm_q[prt_pkg::R_YEAR]);
        end
        // RULE19 - zero bits dropped on write
        if (commit)
            tm_d[ptr_q[5:3]] = commit_byte & commit_mask;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q     <= prt_pkg::ST_LOCKED;
            ptr_q    <= '0;
            shad_q   <= '0;
            wr_any_q <= 1'b0;
            for (int i = 0; i < prt_pkg::N_REGS; i++)
                tm_q[i] <= prt_pkg::TM_RST[i*8 +: 8];
        end else if (clk_en) begin
            st_q  <= st_d;
            ptr_q <= ptr_d;
            for (int i = 0; i < prt_pkg::N_REGS; i++)
                tm_q[i] <= tm_d[i];
            // Snapshot keeps the read image coherent while the clock ticks
            if (unlock)
                shad_q <= tm_img;
            else if (xfer_step)
                shad_q <= shad_nx;
            if (unlock || commit)
                wr_any_q <= 1'b0;
            else if (xfer_step && cyc.wr)
                wr_any_q <= 1'b1;
        end
    end

    // Output stage, all registered
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            memory_select_out_n <= 1'b1;
            data_out            <= 1'b0;
            data_out_oe         <= 1'b0;
        end else if (clk_en) begin
            // RULE22 - RAM mode protect
            // RULE23 - ROM mode forced low
            // RULE9 - memory off during transfer
            // RULE1 - pass-through otherwise
            if (below_trip_level)
                memory_select_out_n <= !rom_mode;
            else if (st_q == prt_pkg::ST_XFER)
                memory_select_out_n <= 1'b1;
            else
                memory_select_out_n <= select_in_n;
            // RULE8 - read drives image bit
            data_out    <= shad_q[ptr_q];
            data_out_oe <= (st_q == prt_pkg::ST_XFER) && !select_in_n && !read_n
                           && write_n && !abort;
        end
    end

    property p_pass;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && st_q != prt_pkg::ST_XFER && !below_trip_level)
        |=> (memory_select_out_n == $past(select_in_n));
    endproperty
    a_pass: assert property (p_pass) else $error("select not passed through"); // RULE1

    property p_arm;
        @(posedge sys_clk) disable iff (!rstn)
        (cyc.rd && !abort && st_q != prt_pkg::ST_XFER)
        |=> (st_q == prt_pkg::ST_MATCH) && (ptr_q == '0);
    endproperty
    a_arm: assert property (p_arm) else $error("read did not arm pointer"); // RULE2

    property p_adv;
        @(posedge sys_clk) disable iff (!rstn)
        (st_q == prt_pkg::ST_MATCH && cyc.wr && key_ok && !abort
         && ptr_q != prt_pkg::LAST_BIT)
        |=> (ptr_q == 6'($past(ptr_q) + 1'b1)) && (st_q == prt_pkg::ST_MATCH);
    endproperty
    a_adv: assert property (p_adv) else $error("pointer did not advance"); // RULE3

    property p_miss;
        @(posedge sys_clk) disable iff (!rstn)
        (st_q == prt_pkg::ST_MISS && cyc.wr && !abort)
        |=> (st_q == prt_pkg::ST_MISS) && $stable(ptr_q);
    endproperty
    a_miss: assert property (p_miss) else $error("write after mismatch acted"); // RULE4

    property p_unlock;
        @(posedge sys_clk) disable iff (!rstn)
        unlock |=> (st_q == prt_pkg::ST_XFER) && (ptr_q == '0)
                   && (shad_q == $past(tm_img));
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock not taken"); // RULE6

    property p_hold_hi;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && st_q == prt_pkg::ST_XFER && !below_trip_level)
        |=> memory_select_out_n;
    endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("memory enabled in transfer"); // RULE9

    property p_step;
        @(posedge sys_clk) disable iff (!rstn)
        (xfer_step && ptr_q != prt_pkg::LAST_BIT)
        |=> (ptr_q == 6'($past(ptr_q) + 1'b1)) && (st_q == prt_pkg::ST_XFER);
    endproperty
    a_step: assert property (p_step) else $error("transfer bit not stepped"); // RULE11

    property p_abort;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && abort)
        |=> (st_q == prt_pkg::ST_LOCKED) && !data_out_oe
            && ($past(tick) || (tm_img == $past(tm_img)));
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not end transfer"); // RULE16

    property p_pf;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && below_trip_level) |=> (memory_select_out_n == !$past(rom_mode));
    endproperty
    a_pf: assert property (p_pf) else $error("wrong select on power fail"); // RULE22

    property p_zero;
        @(posedge sys_clk) disable iff (!rstn)
        ((tm_q[prt_pkg::R_HOUR] & ~prt_pkg::ZERO_MASK[31:24]) == 8'h00)
        && ((tm_q[prt_pkg::R_DAY] & ~prt_pkg::ZERO_MASK[39:32]) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("unused bit set"); // RULE19
endmodule

// File: tb/prt_mem_model.sv
// Memory socket model: counts clock edges at which the attached memory is selected
`timescale 1ns/1ps
module prt_mem_model (
    input  wire logic sys_clk,      // System clock
    input  wire logic rstn,         // Synchronous reset, active low
    input  wire logic mem_select_n, // Memory select from the timekeeper
    output int        hits          // Edges seen with the memory selected
);
    always_ff @(posedge sys_clk) begin
        if (!rstn)
            hits <= 0;
        else if (!mem_select_n)
            hits <= hits + 1;
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the pattern-unlocked timekeeper
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    localparam int          TK      = 10;
    localparam logic [63:0] KEY_SEQ = {8'h5C, 8'hA3, 8'h3A, 8'hC5, 8'h5C, 8'hA3, 8'h3A, 8'hC5};
    logic        sys_clk, rstn, clk_en, select_in_n, read_n, write_n, data_in;
    logic        abort_n, rom_mode, below_trip_level;
    logic        memory_select_out_n, data_out, data_out_oe;
    logic        q, oe, ok;
    logic [63:0] rd_img;
    int          err_count, samples_checked, mem_hits, h;

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    prt_rtc #(.TICK_CYCLES(TK)) i_prt_rtc (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .select_in_n(select_in_n), .read_n(read_n), .write_n(write_n), .data_in(data_in),
        .abort_n(abort_n), .rom_mode(rom_mode), .below_trip_level(below_trip_level),
        .memory_select_out_n(memory_select_out_n), .data_out(data_out),
        .data_out_oe(data_out_oe));

    prt_mem_model i_prt_mem_model (.sys_clk(sys_clk), .rstn(rstn),
        .mem_select_n(memory_select_out_n), .hits(mem_hits));

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One cycle: select held four edges, released data line shows the inverse
    task automatic bus(input logic rd, input logic wr, input logic d, input logic sel,
                       input logic ab, output logic bq, output logic boe);
        @(posedge sys_clk);
        select_in_n <= ~sel;
        read_n      <= ~rd;
        write_n     <= ~wr;
        data_in     <= d;
        abort_n     <= ~ab;
        repeat (3) @(posedge sys_clk);
        #1 bq = data_out;
        boe = data_out_oe;
        @(posedge sys_clk);
        select_in_n <= 1'b1;
        read_n      <= 1'b1;
        write_n     <= 1'b1;
        data_in     <= ~d;
        abort_n     <= 1'b1;
        @(posedge sys_clk);
    endtask

    // unlock sequence, unselected strobes between key bits
    task automatic unlock(input int bad);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
        for (int i = 0; i < 64; i++) begin
            bus(1'b0, 1'b1, ~KEY_SEQ[i], 1'b0, 1'b0, q, oe);
            bus(1'b0, 1'b1, KEY_SEQ[i] ^ (i == bad), 1'b1, 1'b0, q, oe);
        end
    endtask

    // whole registers only: each byte is all written or all read
    task automatic xfer(input logic [63:0] w, input logic [7:0] wr_regs,
                        output logic [63:0] r, output logic all_oe);
        logic bq, boe;
        all_oe = 1'b1;
        for (int n = 0; n < 64; n++) begin
            bus(~wr_regs[n/8], wr_regs[n/8], w[n], 1'b1, 1'b0, bq, boe);
            r[n] = bq;
            if (!wr_regs[n/8] && boe !== 1'b1)
                all_oe = 1'b0;
        end
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0; clk_en = 1'b1; select_in_n = 1'b1; read_n = 1'b1; write_n = 1'b1;
        data_in = 1'b0; abort_n = 1'b1; rom_mode = 1'b0; below_trip_level = 1'b0;
        err_count = 0; samples_checked = 0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1 `CHK(memory_select_out_n, 1'b1)
        `CHK(data_out_oe, 1'b0)
        // Clock enable low must freeze the select path
        @(posedge sys_clk) clk_en <= 1'b0;
        select_in_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 `CHK(memory_select_out_n, 1'b1)
        @(posedge sys_clk) select_in_n <= 1'b1;
        clk_en <= 1'b1;
        h = mem_hits;
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
        // Four edges of select low give four edges of memory select low
        #1 `CHK(32'(mem_hits - h), 32'd4)
        `CHK(oe, 1'b0)
        unlock(-1);
        // Let the last key cycle's memory hit settle before the snapshot
        #1 h = mem_hits;
        xfer(64'h0, 8'h00, rd_img, ok);
        `CHK(rd_img, prt_pkg::TM_RST)
        `CHK(ok, 1'b1)
        `CHK(32'(mem_hits - h), 32'd0)
        // Abort honoured while day bit 4 is zero, even mid read strobe
        unlock(-1);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, q, oe);
        `CHK(oe, 1'b0)
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
        `CHK(oe, 1'b0)
        for (int rm = 0; rm < 2; rm++) begin
            rom_mode <= 1'(rm);
            unlock(-1);
            @(posedge sys_clk) below_trip_level <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 `CHK(memory_select_out_n, 1'(1 - rm))
            @(posedge sys_clk) below_trip_level <= 1'b0;
            bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
            `CHK(oe, 1'b0)
        end
        rom_mode <= 1'b0;
        unlock(63);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
        `CHK(oe, 1'b0)
        // Partial key then a read: recognition must restart from the first bit
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, q, oe);
        for (int i = 0; i < 20; i++)
            bus(1'b0, 1'b1, KEY_SEQ[i], 1'b1, 1'b0, q, oe);
        unlock(-1);
        xfer({8'h99, 8'h12, 8'h31, 8'hFF, 8'hD2, 8'hD9, 8'hD9, 8'h99}, 8'hFF, rd_img, ok);
        unlock(-1);
        bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, q, oe);
        xfer(64'h0, 8'h00, rd_img, ok);
        `CHK(rd_img, 64'h9912_3137_9259_5999)
        unlock(-1);
        xfer(64'h0102_2837_2359_5999, 8'hFF, rd_img, ok);
        unlock(-1);
        xfer(64'h0000_0017_0000_0000, 8'h10, rd_img, ok);
        unlock(-1);
        xfer(64'h0, 8'h00, rd_img, ok);
        `CHK(rd_img[63:8], 56'h01_0301_1100_0000)
        print_verdict();
    end
endmodule
